/* verilog/scpi_message_parser.sv */
// Character-level parser for command program messages
`timescale 1ns/100ps
`include "scpi_parser_map.svh"

// Operation
// - A long form of four letters or fewer has its full spelling as its only short form.
// - A long form of five or more letters shortens to three letters if its fourth is a vowel, else four.
// - Any spelling that is neither the exact short form nor the full long form is an error.
// - Keyword matching ignores letter case.
// - Adjacent keywords are split by a colon and each colon descends one level, stopping at level PATH_DEPTH-1.
// - A question mark right after the final keyword makes the command a query.
// - A parameter follows the final keyword after a single space.
// - Message units in one message are split by semicolons and handled one after another.
// - A character received with end-of-line asserted terminates the message like a line feed.
// - A parameter is accepted as either a numeric value or a string token.
// - A terminator or a root-specifier colon returns the position to the root.
// - Line feed, or any character flagged end-of-line, is the terminator and ends every message.
// - After a semicolon a keyword without a leading colon resolves at the previous unit's level.
module scpi_message_parser #(
	parameter int KW_LEN     = `KW_MAX_LEN,
	parameter int PATH_DEPTH = `PATH_DEPTH
) (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	// Character stream from the host interface
	input  wire logic                  char_valid,
	input  wire logic [7:0]            char_data,
	input  wire logic                  char_eol,
	// Keyword table lookup, one long form offered per keyword
	output logic [8*KW_LEN-1:0]        kw_text,
	output logic [3:0]                 kw_len,
	output logic [2:0]                 kw_level,
	input  wire logic [8*KW_LEN-1:0]   table_long_form,
	input  wire logic [3:0]            table_long_len,
	// Keyword results to command dispatch
	output logic                       kw_accept,
	output logic                       unit_done,
	output logic                       unit_query,
	output logic [1:0]                 unit_param_kind,
	output logic [7:0]                 param_char,
	output logic                       param_char_valid,
	output logic                       msg_done,
	// Status reporting
	output logic                       syntax_error
);

	function automatic logic [7:0] to_upper(input logic [7:0] c);
		return (c >= 8'h61 && c <= 8'h7a) ? (c & ~`CH_CASE_BIT) : c;
	endfunction

	function automatic logic is_letter(input logic [7:0] c);
		return (to_upper(c) >= 8'h41 && to_upper(c) <= 8'h5a);
	endfunction

	function automatic logic is_digit(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39);
	endfunction

	function automatic logic is_numeric_start(input logic [7:0] c);
		return is_digit(c) || c == 8'h2b || c == 8'h2d || c == 8'h2e;
	endfunction

	scpi_parser_pkg::parse_state_t state_q;
	logic [8*KW_LEN-1:0]           text_q;
	logic [3:0]                    len_q;
	logic [2:0]                    level_q;
	logic [2:0]                    unit_base_q;
	logic                          query_q;
	scpi_parser_pkg::param_kind_t  pkind_q;
	logic                          form_ok;
	logic                          term;
	logic                          sep;
	logic                          overflow;

	keyword_form_check #(
		.KW_LEN(KW_LEN)
	) u_form (
		.long_form(table_long_form),
		.long_len (table_long_len),
		.typed    (text_q),
		.typed_len(len_q),
		.match    (form_ok)
	);

	assign kw_text  = text_q;
	assign kw_len   = len_q;
	assign kw_level = level_q;

	// Line feed or any character flagged end-of-line ends the message
	assign term = char_valid && (char_eol || char_data == `CH_LF);
	assign sep  = char_data == `CH_COLON || char_data == `CH_SEMI
		|| char_data == `CH_SPACE || char_data == `CH_QUERY;
	assign overflow = len_q == 4'(KW_LEN);

	// Parse state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= scpi_parser_pkg::ST_KEYWORD;
		end else if (term) begin
			state_q <= scpi_parser_pkg::ST_KEYWORD;
		end else if (char_valid) begin
			case (state_q)
				scpi_parser_pkg::ST_KEYWORD: begin
					if (is_letter(char_data) || is_digit(char_data) || char_data == `CH_STAR) begin
						if (overflow)
							state_q <= scpi_parser_pkg::ST_DISCARD;
					end else if (sep && len_q != 4'h0 && !form_ok) begin
						state_q <= scpi_parser_pkg::ST_DISCARD;
					end else if (char_data == `CH_QUERY) begin
						state_q <= scpi_parser_pkg::ST_QUERY;
					end else if (char_data == `CH_SPACE && len_q != 4'h0) begin
						state_q <= scpi_parser_pkg::ST_PARAM;
					end else if (char_data == `CH_SPACE || char_data == `CH_SEMI
						|| char_data == `CH_COLON) begin
						state_q <= scpi_parser_pkg::ST_KEYWORD;
					end else begin
						state_q <= scpi_parser_pkg::ST_DISCARD;
					end
				end
				scpi_parser_pkg::ST_QUERY: begin
					if (char_data == `CH_SPACE)
						state_q <= scpi_parser_pkg::ST_PARAM;
					else if (char_data == `CH_SEMI)
						state_q <= scpi_parser_pkg::ST_KEYWORD;
					else
						state_q <= scpi_parser_pkg::ST_DISCARD;
				end
				scpi_parser_pkg::ST_PARAM: begin
					if (char_data == `CH_SEMI)
						state_q <= scpi_parser_pkg::ST_KEYWORD;
					else if (is_numeric_start(char_data) || is_letter(char_data))
						state_q <= scpi_parser_pkg::ST_PDATA;
					else
						state_q <= scpi_parser_pkg::ST_DISCARD;
				end
				scpi_parser_pkg::ST_PDATA: begin
					if (char_data == `CH_SEMI)
						state_q <= scpi_parser_pkg::ST_KEYWORD;
				end
				scpi_parser_pkg::ST_DISCARD: begin
					state_q <= scpi_parser_pkg::ST_DISCARD;
				end
				default: begin
					state_q <= scpi_parser_pkg::ST_DISCARD;
				end
			endcase
		end
	end

	// Keyword collection, folded to upper case before matching
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			text_q <= '0;
			len_q  <= 4'h0;
		end else if (term || (char_valid && (sep || state_q != scpi_parser_pkg::ST_KEYWORD))) begin
			text_q <= '0;
			len_q  <= 4'h0;
		end else if (char_valid && !overflow) begin
			text_q[8*len_q +: 8] <= to_upper(char_data);
			len_q                <= len_q + 4'h1;
		end
	end

	// Hierarchy position
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			level_q     <= 3'h0;
			unit_base_q <= 3'h0;
		end else if (term) begin
			level_q     <= 3'h0;
			unit_base_q <= 3'h0;
		end else if (char_valid && state_q == scpi_parser_pkg::ST_KEYWORD) begin
			if (char_data == `CH_COLON && len_q == 4'h0) begin
				// Root colon also resets the base a later semicolon returns to
				level_q     <= 3'h0;
				unit_base_q <= 3'h0;
			end else if (char_data == `CH_COLON && form_ok) begin
				// Depth saturates; deeper paths keep matching at the last level
				if (level_q != 3'(PATH_DEPTH - 1)) begin
					level_q     <= level_q + 3'h1;
					unit_base_q <= level_q + 3'h1;
				end else begin
					unit_base_q <= level_q;
				end
			end else if (char_data == `CH_SEMI) begin
				level_q <= unit_base_q;
			end
		end else if (char_valid && char_data == `CH_SEMI
			&& state_q != scpi_parser_pkg::ST_DISCARD) begin
			level_q <= unit_base_q;
		end
	end

	// Unit attributes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			query_q <= 1'b0;
			pkind_q <= scpi_parser_pkg::PK_NONE;
		end else if (term || (char_valid && char_data == `CH_SEMI)) begin
			query_q <= 1'b0;
			pkind_q <= scpi_parser_pkg::PK_NONE;
		end else if (char_valid) begin
			if (state_q == scpi_parser_pkg::ST_KEYWORD && char_data == `CH_QUERY && form_ok)
				query_q <= 1'b1;
			if (state_q == scpi_parser_pkg::ST_PARAM)
				pkind_q <= is_numeric_start(char_data) ? scpi_parser_pkg::PK_NUMERIC
					: scpi_parser_pkg::PK_STRING;
		end
	end

	// Result strobes, one cycle after the deciding character
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			kw_accept        <= 1'b0;
			unit_done        <= 1'b0;
			unit_query       <= 1'b0;
			unit_param_kind  <= 2'h0;
			param_char       <= 8'h00;
			param_char_valid <= 1'b0;
			msg_done         <= 1'b0;
			syntax_error     <= 1'b0;
		end else begin
			kw_accept        <= char_valid && state_q == scpi_parser_pkg::ST_KEYWORD
				&& (sep || term) && len_q != 4'h0 && form_ok;
			unit_done        <= char_valid && (char_data == `CH_SEMI || term)
				&& state_q != scpi_parser_pkg::ST_DISCARD
				&& !(state_q == scpi_parser_pkg::ST_KEYWORD && len_q != 4'h0 && !form_ok);
			unit_query       <= query_q || (char_valid && char_data == `CH_QUERY);
			unit_param_kind  <= pkind_q;
			param_char       <= char_data;
			param_char_valid <= char_valid && !term && char_data != `CH_SEMI
				&& (state_q == scpi_parser_pkg::ST_PDATA
				|| (state_q == scpi_parser_pkg::ST_PARAM && char_data != `CH_SPACE));
			msg_done         <= term;
			// Error flagged once, on entry to discard or on a bad keyword at terminator
			syntax_error     <= char_valid && state_q != scpi_parser_pkg::ST_DISCARD
				&& ((state_q == scpi_parser_pkg::ST_KEYWORD && (sep || term)
				&& len_q != 4'h0 && !form_ok)
				|| (!term && state_q == scpi_parser_pkg::ST_KEYWORD && !sep
				&& !is_letter(char_data) && !is_digit(char_data) && char_data != `CH_STAR)
				|| (!term && state_q == scpi_parser_pkg::ST_KEYWORD && overflow && !sep)
				|| (!term && state_q == scpi_parser_pkg::ST_QUERY
				&& char_data != `CH_SPACE && char_data != `CH_SEMI)
				|| (!term && state_q == scpi_parser_pkg::ST_PARAM && char_data != `CH_SEMI
				&& !is_numeric_start(char_data) && !is_letter(char_data)));
		end
	end

endmodule

/* verilog/scpi_parser_map.svh */
// Character codes, limits and field widths for the command message parser
`ifndef SCPI_PARSER_MAP_SVH
`define SCPI_PARSER_MAP_SVH

`define CH_LF        8'h0a
`define CH_SPACE     8'h20
`define CH_COLON     8'h3a
`define CH_SEMI      8'h3b
`define CH_QUERY     8'h3f
`define CH_STAR      8'h2a
`define CH_COMMA     8'h2c
`define CH_CASE_BIT  8'h20
`define KW_SHORT_MAX 4'h4
`define KW_LONG_MIN  4'h5
`define KW_MAX_LEN   12
`define PATH_DEPTH   8

`endif

/* verilog/scpi_parser_pkg.sv */
// Types shared by the command message parser
package scpi_parser_pkg;

	typedef enum logic [2:0] {
		ST_KEYWORD = 3'h0,
		ST_QUERY   = 3'h1,
		ST_PARAM   = 3'h3,
		ST_PDATA   = 3'h2,
		ST_DISCARD = 3'h6
	} parse_state_t;

	typedef enum logic [1:0] {
		PK_NONE    = 2'h0,
		PK_NUMERIC = 2'h1,
		PK_STRING  = 2'h2
	} param_kind_t;

endpackage

/* verilog/keyword_form_check.sv */
// Decides whether a typed keyword is a legal short or long form of a table entry
`timescale 1ns/100ps
`include "scpi_parser_map.svh"

module keyword_form_check #(
	parameter int KW_LEN = `KW_MAX_LEN
) (
	// Candidate long form, upper case, left aligned, byte 0 first
	input  wire logic [8*KW_LEN-1:0] long_form,
	input  wire logic [3:0]          long_len,
	// Typed keyword, already folded to upper case
	input  wire logic [8*KW_LEN-1:0] typed,
	input  wire logic [3:0]          typed_len,
	// Verdict
	output logic                     match
);

	function automatic logic is_vowel(input logic [7:0] c);
		return c == 8'h41 || c == 8'h45 || c == 8'h49 || c == 8'h4f || c == 8'h55;
	endfunction

	logic [3:0] short_len;
	logic       prefix_ok;

	always_comb begin
		// Length of the short form from the long form
		if (long_len <= `KW_SHORT_MAX)
			short_len = long_len;
		else if (is_vowel(long_form[8*3 +: 8]))
			short_len = 4'h3;
		else
			short_len = 4'h4;
		prefix_ok = 1'b1;
		for (int i = 0; i < KW_LEN; i++) begin
			if (4'(i) < typed_len && typed[8*i +: 8] != long_form[8*i +: 8])
				prefix_ok = 1'b0;
		end
		// Only the exact short or full long length passes; truncations in between fail
		match = prefix_ok && typed_len != 4'h0
			&& (typed_len == short_len || typed_len == long_len);
	end

endmodule

/* test/scpi_parser_props.sv */
// Port checks for the command message parser
`timescale 1ns/100ps
module scpi_parser_props (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rstn,
	// Character stream
	input wire logic       char_valid,
	input wire logic [7:0] char_data,
	input wire logic       char_eol,
	// Results
	input wire logic [2:0] kw_level,
	input wire logic       kw_accept,
	input wire logic       unit_done,
	input wire logic [1:0] unit_param_kind,
	input wire logic [7:0] param_char,
	input wire logic       param_char_valid,
	input wire logic       msg_done,
	input wire logic       syntax_error
);
	logic       drop_q;
	logic       seen_q;
	logic [1:0] kind_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_term;
		char_valid && (char_eol || char_data == 8'h0a);
	endsequence
	sequence s_eol;
		char_valid && char_eol;
	endsequence
	// Discard window: an early clear would hide output leaking after an error
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			drop_q <= 1'b0;
		else
			drop_q <= (drop_q || syntax_error) && !msg_done;
	end
	// Kind expected from the first parameter byte of the unit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			seen_q <= 1'b0;
			kind_q <= 2'h0;
		end else if (unit_done || msg_done) begin
			seen_q <= 1'b0;
			kind_q <= 2'h0;
		end else if (param_char_valid && !seen_q) begin
			seen_q <= 1'b1;
			kind_q <= (param_char inside {[8'h30:8'h39], 8'h2b, 8'h2d, 8'h2e}) ? 2'h1 : 2'h2;
		end
	end
	AST_LF_DONE: assert property (s_term |=> msg_done) else $error("no msg_done");
	AST_EOL_DONE: assert property (s_eol |=> msg_done && kw_level == 3'h0) else $error("eol");
	AST_MSG_CAUSE: assert property (msg_done |-> $past(char_valid && (char_eol || char_data == 8'h0a)))
		else $error("stray msg_done");
	AST_ROOT: assert property (msg_done |-> kw_level == 3'h0) else $error("not at root");
	AST_UNIT_CAUSE: assert property (unit_done |-> $past(char_valid)
		&& $past(char_eol || char_data == 8'h0a || char_data == 8'h3b)) else $error("unit");
	AST_SILENT: assert property (drop_q |-> !unit_done && !kw_accept && !param_char_valid)
		else $error("output while dropping");
	AST_ERR_CAUSE: assert property (syntax_error |-> $past(char_valid)) else $error("stray err");
	AST_PARAM: assert property (param_char_valid |-> $past(char_valid) && param_char == $past(char_data))
		else $error("param byte");
	AST_KIND: assert property (unit_done |-> unit_param_kind == kind_q) else $error("kind");
	AST_ACCEPT: assert property (kw_accept |-> $past(char_valid) && $past(char_eol
		|| char_data inside {8'h3a, 8'h3b, 8'h20, 8'h3f, 8'h0a})) else $error("accept");
endmodule
bind scpi_message_parser scpi_parser_props u_props (.clk_sys, .rstn, .char_valid, .char_data,
	.char_eol, .kw_level, .kw_accept, .unit_done, .unit_param_kind, .param_char,
	.param_char_valid, .msg_done, .syntax_error);

/* test/scpi_host_model.sv */
// Host side model streaming program message characters
`timescale 1ns/100ps
module scpi_host_model (
	// Clock
	input wire logic   clk_sys,
	// Character stream
	output logic       char_valid,
	output logic [7:0] char_data,
	output logic       char_eol
);
	initial begin
		char_valid = 1'b0;
		char_data  = 8'h00;
		char_eol   = 1'b0;
	end
	// Whole message in one go, every letter sent, terminator last
	task automatic send(input string s, input bit eol_end);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge clk_sys);
			char_valid = 1'b1;
			char_data  = s[i];
			char_eol   = eol_end && (i == s.len() - 1);
		end
		@(negedge clk_sys);
		// Released line must not keep showing the last byte
		char_valid = 1'b0;
		char_data  = ~char_data;
		char_eol   = 1'b0;
	endtask
endmodule

/* test/scpi_message_parser_tb_top.sv */
// Testbench for the command message parser
`timescale 1ns/100ps
module scpi_message_parser_tb_top;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic        char_valid, char_eol, kw_accept, unit_done, unit_query;
	logic [7:0]  char_data, param_char;
	logic [95:0] kw_text, table_long_form;
	logic [3:0]  kw_len, table_long_len;
	logic [2:0]  kw_level;
	logic [1:0]  unit_param_kind, last_kind;
	logic [7:0]  lvl_log;
	logic        param_char_valid, msg_done, syntax_error, last_query;
	int          error_cnt = 0;
	int          checks = 0;
	int          n_acc, n_unit, n_msg, n_err;
	string       tbl[6] = '{"VOLTAGE", "MEASURE", "MODE", "LEVEL", "OUTPUT", "IMMEDIATE"};
	always #4 clk_sys = ~clk_sys;
	scpi_host_model u_host (.clk_sys, .char_valid, .char_data, .char_eol);
	scpi_message_parser dut (.clk_sys, .rstn, .char_valid, .char_data, .char_eol, .kw_text,
		.kw_len, .kw_level, .table_long_form, .table_long_len, .kw_accept, .unit_done,
		.unit_query, .unit_param_kind, .param_char, .param_char_valid, .msg_done, .syntax_error);
	// Keyword table keyed on the first three letters only
	always @* begin
		table_long_form = '0;
		table_long_len  = 4'h0;
		foreach (tbl[i])
			if (kw_text[23:0] == {tbl[i][2], tbl[i][1], tbl[i][0]}) begin
				for (int j = 0; j < tbl[i].len(); j++)
					table_long_form[8*j+:8] = tbl[i][j];
				table_long_len = 4'(tbl[i].len());
			end
	end
	always @(posedge clk_sys) begin
		n_acc  <= n_acc + int'(kw_accept === 1'b1);
		n_msg  <= n_msg + int'(msg_done === 1'b1);
		n_err  <= n_err + int'(syntax_error === 1'b1);
		n_unit <= n_unit + int'(unit_done === 1'b1);
		// Level seen by dispatch at each accepted keyword, two bits per entry
		if (kw_accept === 1'b1)
			lvl_log <= {lvl_log[5:0], kw_level[1:0]};
		if (unit_done === 1'b1) begin
			last_query <= unit_query;
			last_kind  <= unit_param_kind;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic run(input string s, input bit e, input int a, u, er, input logic q,
		input logic [1:0] k, input logic [7:0] lv);
		@(negedge clk_sys);
		{n_acc, n_unit, n_msg, n_err} = '0;
		last_query = 1'bx;
		last_kind  = 2'bxx;
		lvl_log    = 8'hff;
		u_host.send(s, e);
		repeat (3) @(negedge clk_sys);
		chk(8'(n_acc), 8'(a));
		chk(8'(n_unit), 8'(u));
		chk(8'(n_msg), 8'h01);
		chk(8'(n_err), 8'(er));
		if (u > 0) chk({7'h0, last_query}, {7'h0, q});
		if (u > 0) chk({6'h0, last_kind}, {6'h0, k});
		chk(lvl_log, lv);
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic s_query;     run("VOLT?\n", 0, 1, 1, 0, 1, 2'h0, 8'hfc); endtask
	task automatic s_long_num;  run("vOlTaGe 5\n", 0, 1, 1, 0, 0, 2'h1, 8'hfc); endtask
	task automatic s_four;      run("MODE ON\n", 0, 1, 1, 0, 0, 2'h2, 8'hfc); endtask
	task automatic s_bad_long;  run("VOLTA:LEV 1\n", 0, 0, 0, 1, 0, 2'h0, 8'hff); endtask
	task automatic s_bad_short; run("IMME\n", 0, 0, 0, 1, 0, 2'h0, 8'hff); endtask
	task automatic s_overflow;  run("ABCDEFGHIJKLM\n", 0, 0, 0, 1, 0, 2'h0, 8'hff); endtask
	task automatic s_units;     run("MEAS:VOLT?;LEV 5\n", 0, 3, 2, 0, 0, 2'h1, 8'hd5); endtask
	task automatic s_eol;       run("OUTP?x", 1, 1, 1, 0, 1, 2'h0, 8'hfc); endtask
	task automatic s_root;      run(":MEAS:VOLT?;:MODE 1\n", 0, 3, 2, 0, 0, 2'h1, 8'hd4); endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		rstn = 1'b1;
		s_query;
		s_long_num;
		s_four;
		s_bad_long;
		s_bad_short;
		s_overflow;
		s_units;
		s_eol;
		s_root;
		finish_test;
	end
	initial begin
		repeat (2000) @(posedge clk_sys);
		error_cnt++;
		$display("MISMATCH t=%0t watchdog", $time);
		finish_test;
	end
endmodule
